// ==== pkg/wdtr_pkg.sv ====
// package for the watchdog timer with reset: offsets, fields, resets, timing
package wdtr_pkg;
  // register byte offsets
  localparam logic [11:0] wdtr_off_ctrl = 12'h000;
  localparam logic [11:0] wdtr_off_cfg = 12'h004;
  localparam logic [11:0] wdtr_off_irq_stat = 12'h008;
  localparam logic [11:0] wdtr_off_irq_mask = 12'h00c;
  localparam logic [11:0] wdtr_off_unlock = 12'h010;
  localparam logic [11:0] wdtr_off_count = 12'h014;
  // control/status field positions
  localparam int wdtr_bit_restart = 0;
  localparam int wdtr_bit_rst_en = 1;
  localparam int wdtr_bit_cause = 2;
  localparam int wdtr_bit_timeout = 3;
  // config field positions
  localparam int wdtr_bit_sel_lo = 0;
  localparam int wdtr_bit_sel_hi = 1;
  localparam int wdtr_bit_run = 2;
  localparam int wdtr_bit_gie = 3;
  localparam int wdtr_bit_wdie = 4;
  // irq status bits
  localparam int wdtr_irq_timeout = 0;
  localparam int wdtr_irq_wdreset = 1;
  // unlock keys, written in this order
  localparam logic [7:0] wdtr_key1 = 8'haa;
  localparam logic [7:0] wdtr_key2 = 8'h55;
  // timing
  localparam int wdtr_cnt_w = 26;
  localparam int wdtr_grace_clks = 512;
  localparam int wdtr_mcycle_clks = 4;
  localparam int wdtr_rst_mcycles = 2;
  localparam int wdtr_rst_clks = wdtr_mcycle_clks * wdtr_rst_mcycles;
  localparam int wdtr_unlock_window = 3;
  localparam logic [31:0] wdtr_int_sel0 = 32'h0002_0000;
  localparam logic [31:0] wdtr_int_sel1 = 32'h0010_0000;
  localparam logic [31:0] wdtr_int_sel2 = 32'h0080_0000;
  localparam logic [31:0] wdtr_int_sel3 = 32'h0400_0000;
  // reset values
  localparam logic [1:0] wdtr_rst_sel = 2'h0;
  localparam logic [1:0] wdtr_rst_mask = 2'h0;

  typedef enum logic [2:0] {
    wdtr_st_count = 3'b001,
    wdtr_st_grace = 3'b010,
    wdtr_st_reset = 3'b100
  } wdtr_state_e;

  typedef struct packed {
    wdtr_state_e st;
    logic [wdtr_cnt_w-1:0] cnt;
    logic [9:0] grace;
    logic [3:0] rst_cnt;
    logic [1:0] sel;
    logic run;
    logic gie;
    logic wdie;
    logic rst_en;
    logic tmo_flag;
    logic cause_flag;
    logic restart;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] unlock_st;
    logic [1:0] unlock_tmr;
    logic [31:0] rdata;
    logic por_done;
  } wdtr_regs_s;
endpackage : wdtr_pkg

// ==== rtl/wdtr_top.sv ====
// watchdog timer with reset generation behind an apb slave
// Summary of operation
// - restart bit clears count, self clears
// - counter advances every clock while running, except during system reset
// - select picks 2^17/2^20/2^23/2^26 clocks
// - each elapsed interval sets time-out flag
// - no restart 512 clocks after: reset
// - reset lasts two machine cycles, cause set
// - without reset or irq, plain interval timer
// - irq needs flag, enable and global enable
// - time-out flag cleared by zero or reset
// - cause flag sticky, power-fail reset clears
// - reset disabled never touches cause flag
// - reset enable off keeps counter running
// - power reset disables, watchdog reset restarts
// - protected writes need timed unlock
// - power-on clears enable and cause; pin keeps
`timescale 1ns/1ps
module wdtr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_reset_n,
  input wire logic irq_other_ok,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wd_irq,
  output logic irq,
  output logic wd_sys_reset
);
  wdtr_pkg::wdtr_regs_s s_reg;
  wdtr_pkg::wdtr_regs_s s_next;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_sync_d_reg;

  // pin reset enters from outside: three flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      pin_sync_d_reg <= 1'b1;
    end else begin
      pin_meta_reg <= pin_reset_n;
      pin_sync_reg <= pin_meta_reg;
      pin_sync_d_reg <= pin_sync_reg;
    end
  end

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    addr_hit = (a == off);
  endfunction : addr_hit

  function automatic logic [31:0] interval_len(input logic [1:0] sel);
    unique case (sel)
      2'h0: interval_len = wdtr_pkg::wdtr_int_sel0;
      2'h1: interval_len = wdtr_pkg::wdtr_int_sel1;
      2'h2: interval_len = wdtr_pkg::wdtr_int_sel2;
      2'h3: interval_len = wdtr_pkg::wdtr_int_sel3;
    endcase
  endfunction : interval_len

  logic wr;
  logic rd;
  logic unlocked;
  logic pin_rst;
  logic tmo_evt;
  logic [31:0] cnt_ext;
  logic [31:0] len;
  logic [wdtr_pkg::wdtr_cnt_w-1:0] lenm1;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign unlocked = (s_reg.unlock_st == 2'h2);
  assign pin_rst = !pin_sync_d_reg;
  assign len = interval_len(s_reg.sel);
  assign lenm1 = len[wdtr_pkg::wdtr_cnt_w-1:0] - 26'h1;
  assign cnt_ext = {6'h0, s_reg.cnt};
  assign tmo_evt = s_reg.run && (s_reg.st != wdtr_pkg::wdtr_st_reset)
                   && (s_reg.cnt == lenm1);

  always_comb begin
    s_next = s_reg;
    s_next.restart = 1'b0;
    // timed access: key1 then key2, then one protected write in a short window
    if (s_reg.unlock_tmr != 2'h0) begin
      s_next.unlock_tmr = s_reg.unlock_tmr - 2'h1;
    end else begin
      s_next.unlock_st = 2'h0;
    end
    if (s_reg.run && s_reg.st != wdtr_pkg::wdtr_st_reset) begin
      s_next.cnt = s_reg.cnt + 26'h1;
    end
    unique case (s_reg.st)
      wdtr_pkg::wdtr_st_count: begin
        if (tmo_evt) begin
          s_next.cnt = '0;
          s_next.tmo_flag = 1'b1;
          s_next.irq_stat[wdtr_pkg::wdtr_irq_timeout] = 1'b1;
          s_next.grace = '0;
          if (s_reg.rst_en) begin
            s_next.st = wdtr_pkg::wdtr_st_grace;
          end
        end
      end
      wdtr_pkg::wdtr_st_grace: begin
        s_next.grace = s_reg.grace + 10'h1;
        if (!s_reg.rst_en) begin
          s_next.st = wdtr_pkg::wdtr_st_count;
        end else if (s_reg.grace == 10'(wdtr_pkg::wdtr_grace_clks - 1)) begin
          s_next.st = wdtr_pkg::wdtr_st_reset;
          s_next.rst_cnt = '0;
          s_next.cause_flag = 1'b1;
          s_next.irq_stat[wdtr_pkg::wdtr_irq_wdreset] = 1'b1;
        end
      end
      wdtr_pkg::wdtr_st_reset: begin
        s_next.rst_cnt = s_reg.rst_cnt + 4'h1;
        if (s_reg.rst_cnt == 4'(wdtr_pkg::wdtr_rst_clks - 1)) begin
          s_next.st = wdtr_pkg::wdtr_st_count;
          s_next.cnt = '0;
          s_next.tmo_flag = 1'b0;
        end
      end
    endcase
    if (wr) begin
      if (addr_hit(paddr, wdtr_pkg::wdtr_off_unlock) && pstrb[0]) begin
        if (pwdata[7:0] == wdtr_pkg::wdtr_key1) begin
          s_next.unlock_st = 2'h1;
          s_next.unlock_tmr = 2'(wdtr_pkg::wdtr_unlock_window);
        end else if (pwdata[7:0] == wdtr_pkg::wdtr_key2 && s_reg.unlock_st == 2'h1) begin
          s_next.unlock_st = 2'h2;
          s_next.unlock_tmr = 2'(wdtr_pkg::wdtr_unlock_window);
        end else begin
          s_next.unlock_st = 2'h0;
        end
      end
      if (addr_hit(paddr, wdtr_pkg::wdtr_off_ctrl) && pstrb[0]) begin
        if (unlocked) begin
          s_next.unlock_st = 2'h0;
          s_next.rst_en = pwdata[wdtr_pkg::wdtr_bit_rst_en];
          if (!pwdata[wdtr_pkg::wdtr_bit_timeout] && !tmo_evt) begin
            s_next.tmo_flag = 1'b0;
          end
          if (pwdata[wdtr_pkg::wdtr_bit_restart] && s_reg.st != wdtr_pkg::wdtr_st_reset) begin
            s_next.restart = 1'b1;
            s_next.cnt = '0;
            s_next.st = wdtr_pkg::wdtr_st_count;
          end
        end
        // cause flag is unprotected; a new watchdog reset wins over the clear
        if (!pwdata[wdtr_pkg::wdtr_bit_cause] && s_next.st != wdtr_pkg::wdtr_st_reset) begin
          s_next.cause_flag = 1'b0;
        end
      end
      if (addr_hit(paddr, wdtr_pkg::wdtr_off_cfg) && pstrb[0]) begin
        s_next.sel = {pwdata[wdtr_pkg::wdtr_bit_sel_hi], pwdata[wdtr_pkg::wdtr_bit_sel_lo]};
        s_next.run = pwdata[wdtr_pkg::wdtr_bit_run];
        s_next.gie = pwdata[wdtr_pkg::wdtr_bit_gie];
        s_next.wdie = pwdata[wdtr_pkg::wdtr_bit_wdie];
      end
      if (addr_hit(paddr, wdtr_pkg::wdtr_off_irq_stat) && pstrb[0]) begin
        // write one to clear, a same-cycle event keeps its bit only if that bit was clear before
        s_next.irq_stat = s_next.irq_stat & ~(pwdata[1:0] & ~(s_next.irq_stat & ~s_reg.irq_stat));
      end
      if (addr_hit(paddr, wdtr_pkg::wdtr_off_irq_mask) && pstrb[0]) begin
        s_next.irq_mask = pwdata[1:0];
      end
    end
    if (pin_rst) begin
      // pin reset: counter restarts, flag cleared, enable and cause kept
      s_next.st = wdtr_pkg::wdtr_st_count;
      s_next.cnt = '0;
      s_next.tmo_flag = 1'b0;
    end
    s_next.rdata = 32'h0;
    if (rd) begin
      if (addr_hit(paddr, wdtr_pkg::wdtr_off_ctrl)) begin
        s_next.rdata = {28'h0, s_reg.tmo_flag, s_reg.cause_flag, s_reg.rst_en, s_reg.restart};
      end else if (addr_hit(paddr, wdtr_pkg::wdtr_off_cfg)) begin
        s_next.rdata = {27'h0, s_reg.wdie, s_reg.gie, s_reg.run, s_reg.sel};
      end else if (addr_hit(paddr, wdtr_pkg::wdtr_off_irq_stat)) begin
        s_next.rdata = {30'h0, s_reg.irq_stat};
      end else if (addr_hit(paddr, wdtr_pkg::wdtr_off_irq_mask)) begin
        s_next.rdata = {30'h0, s_reg.irq_mask};
      end else if (addr_hit(paddr, wdtr_pkg::wdtr_off_count)) begin
        s_next.rdata = cnt_ext;
      end
    end
  end

  // power reset disables watchdog and clears enable and cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{st: wdtr_pkg::wdtr_st_count, sel: wdtr_pkg::wdtr_rst_sel,
                 irq_mask: wdtr_pkg::wdtr_rst_mask, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  logic unmapped;
  assign unmapped = !(addr_hit(paddr, wdtr_pkg::wdtr_off_ctrl) || addr_hit(paddr, wdtr_pkg::wdtr_off_cfg)
                   || addr_hit(paddr, wdtr_pkg::wdtr_off_irq_stat) || addr_hit(paddr, wdtr_pkg::wdtr_off_irq_mask)
                   || addr_hit(paddr, wdtr_pkg::wdtr_off_unlock) || addr_hit(paddr, wdtr_pkg::wdtr_off_count));
  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped;
  // read data is not registered: it goes out combinationally from the access cycle value
  assign prdata = rd ? s_next.rdata : 32'h0;
  assign wd_irq = s_reg.tmo_flag && s_reg.wdie && s_reg.gie && irq_other_ok;
  assign irq = |(s_reg.irq_stat & s_reg.irq_mask);
  assign wd_sys_reset = (s_reg.st == wdtr_pkg::wdtr_st_reset);
endmodule : wdtr_top

// ==== verif/wdtr_checker.sv ====
// port-level assertion checker for the watchdog apb block
`timescale 1ns/1ps
module wdtr_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_other_ok,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wd_irq,
  input wire logic wd_sys_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam int min_gap = 131584;
  // cycles since the last system reset; a lower bound only, since restarts just lengthen it
  logic [17:0] gap_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_reg <= '0;
    else if (wd_sys_reset) gap_reg <= '0;
    else if (gap_reg != '1) gap_reg <= gap_reg + 18'h1;
  end
  rst_gap_a: assert property ($rose(wd_sys_reset) |-> gap_reg >= min_gap)
    else $error("system reset came too early");
  rst_len_a: assert property ($rose(wd_sys_reset) |-> wd_sys_reset [*8] ##1 !wd_sys_reset)
    else $error("system reset length wrong");
  rst_quiet_a: assert property ($fell(wd_sys_reset) |-> !wd_sys_reset [*8])
    else $error("system reset repeated at once");
  irq_gate_a: assert property (wd_irq |-> irq_other_ok)
    else $error("watchdog irq without other conditions");
  ready_a: assert property (psel && penable |-> pready)
    else $error("access not completed");
  unmapped_a: assert property (psel && penable && paddr >= 12'h018 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_a: assert property (psel && penable && paddr < 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  idle_bus_a: assert property (!(psel && penable) |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside access");
endmodule : wdtr_checker

// ==== verif/wdtr_top_tb.sv ====
// self-checking bench for the watchdog apb block
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module wdtr_top_tb;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic err;} wdtr_row_s;
  localparam wdtr_row_s rows [9] = '{
    '{1'h0, 12'h000, 32'h0, 32'h0, 1'h0}, '{1'h0, 12'h004, 32'h0, 32'h0, 1'h0},
    '{1'h0, 12'h014, 32'h0, 32'h0, 1'h0}, '{1'h0, 12'h008, 32'h0, 32'h0, 1'h0},
    '{1'h1, 12'h000, 32'h2, 32'h0, 1'h0}, '{1'h0, 12'h000, 32'h0, 32'h0, 1'h0},
    '{1'h1, 12'h00c, 32'h3, 32'h0, 1'h0}, '{1'h0, 12'h00c, 32'h0, 32'h3, 1'h0},
    '{1'h0, 12'h018, 32'h0, 32'h0, 1'h1}};
  logic pclk = 1'h0, presetn = 1'h0, pin_reset_n = 1'h1, irq_other_ok = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, c;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, wd_irq, irq, wd_sys_reset;
  int n_errors = 0, checks_done = 0, cyc = 0, n;
  wdtr_top u_wdtr_top (.pclk(pclk), .presetn(presetn), .pin_reset_n(pin_reset_n), .irq_other_ok(irq_other_ok),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wd_irq(wd_irq), .irq(irq), .wd_sys_reset(wd_sys_reset));
  initial forever #4 pclk = ~pclk;
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 150000) begin
      n_errors++;
      close_out();
    end
  end
  // leaves psel high so a following call runs back to back
  // answer is read mid-cycle, where it still holds the value the closing edge sees
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    logic ok;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    forever begin
      @(negedge pclk);
      rd = prdata;
      er = pslverr;
      ok = pready;
      @(posedge pclk);
      if (ok === 1'h1) break;
      k++;
      if (k >= 16) begin
        n_errors++;
        $display("BAD %0t bus access never completed", $time);
        break;
      end
    end
  endtask : apb
  task automatic idle();
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : idle
  task automatic wait_hi(ref logic s, output int m);
    m = 0;
    while (s !== 1'h1 && m < 140000) begin
      @(negedge pclk);
      m++;
    end
    if (s !== 1'h1) begin
      n_errors++;
      $display("BAD %0t awaited output never rose", $time);
    end
    @(posedge pclk);
  endtask : wait_hi
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK(rd, rows[i].e)
      `CHK(er, rows[i].err)
    end
    apb(1'h1, 12'h010, 32'haa);
    apb(1'h1, 12'h010, 32'h55);
    apb(1'h1, 12'h000, 32'h3);
    apb(1'h1, 12'h004, 32'h1c);
    apb(1'h0, 12'h014, 32'h0);
    c = rd;
    apb(1'h0, 12'h014, 32'h0);
    `CHK(rd - c, 32'h2)
    apb(1'h0, 12'h000, 32'h0);
    `CHK(rd, 32'h2)
    idle();
    wait_hi(wd_irq, n);
    `CHK(32'(n), 32'h20000 - c - 32'h5)
    `CHK(irq, 1'h1)
    irq_other_ok <= 1'h0;
    repeat (2) @(posedge pclk);
    `CHK(wd_irq, 1'h0)
    irq_other_ok <= 1'h1;
    wait_hi(wd_sys_reset, n);
    `CHK(n > 505 && n < 515, 1'h1)
    repeat (12) @(posedge pclk);
    apb(1'h0, 12'h000, 32'h0);
    `CHK(rd, 32'h6)
    apb(1'h0, 12'h004, 32'h0);
    `CHK(rd, 32'h1c)
    apb(1'h0, 12'h008, 32'h0);
    `CHK(rd, 32'h3)
    `CHK(irq, 1'h1)
    apb(1'h1, 12'h00c, 32'h0);
    apb(1'h1, 12'h008, 32'h3);
    apb(1'h0, 12'h008, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(irq, 1'h0)
    apb(1'h1, 12'h000, 32'h0);
    apb(1'h0, 12'h000, 32'h0);
    `CHK(rd, 32'h2)
    idle();
    pin_reset_n <= 1'h0;
    repeat (8) @(posedge pclk);
    pin_reset_n <= 1'h1;
    repeat (6) @(posedge pclk);
    apb(1'h0, 12'h000, 32'h0);
    `CHK(rd, 32'h2)
    apb(1'h0, 12'h014, 32'h0);
    `CHK(rd < 32'h18, 1'h1)
    idle();
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, 12'h000, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'h0, 12'h004, 32'h0);
    `CHK(rd, 32'h0)
    idle();
    close_out();
  end
endmodule : wdtr_top_tb
bind wdtr_top wdtr_checker u_wdtr_checker (.pclk(pclk), .presetn(presetn), .irq_other_ok(irq_other_ok),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wd_irq(wd_irq), .wd_sys_reset(wd_sys_reset));
